/* hw/arf_pkg.sv */
// Package: register map, field layout and reset values of the result formatter
package arf_pkg;
    // Register offsets (byte addresses of the CPU register port)
    localparam logic [7:0] ADDR_STATUS_CTRL = 8'h57;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h59;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h5A;
    localparam logic [7:0] ADDR_SCAN_ONE = 8'h5B;
    localparam logic [7:0] ADDR_SCAN_TWO = 8'h5C;
    localparam logic [7:0] ADDR_SCAN_THREE = 8'h5D;
    localparam logic [7:0] ADDR_SCAN_CONTROL = 8'h5E;
    localparam logic [7:0] ADDR_MODE_CONTROL = 8'h60;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h61;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h62;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h63;
    // Status and control register fields
    localparam int SC_DONE_BIT = 7;
    localparam int SC_IRQEN_BIT = 6;
    localparam int SC_CONT_BIT = 5;
    // Scan control fields
    localparam int SCAN_EN_BIT = 2;
    localparam int SCAN_CNT_LO = 0;
    // Mode control field position
    localparam int MODE_LO = 0;
    // Justification modes
    localparam logic [1:0] MODE_TRUNC = 2'h0;
    localparam logic [1:0] MODE_RIGHT = 2'h1;
    localparam logic [1:0] MODE_LEFT = 2'h2;
    localparam logic [1:0] MODE_LSIGN = 2'h3;
    // Reset values
    localparam logic [1:0] MODE_RESET = MODE_RIGHT;
    localparam logic [1:0] SCAN_CNT_RESET = 2'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // Sticky event bits
    localparam int EV_CONV = 0;
    localparam int EV_LOST = 1;
    localparam int EV_CYCLE = 2;
    localparam int EV_NUM = 3;
    // Scan sequencer states, one-hot
    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b01,
        SCAN_RUN = 2'b10
    } arf_scan_state_t;
endpackage

/* hw/arf_core.sv */
// Result formatting, read-order interlock and auto-scan control for a 10-bit converter
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module arf_core
    import arf_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // CPU register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // Converter core
    input wire logic conv_done_in,
    input wire logic [9:0] conv_data_in,
    output logic [1:0] conv_input_out,
    output logic conv_start_out,
    // Control levels
    output logic continuous_convert_out,
    output logic scan_active_out,
    // Interrupts
    output logic conv_irq_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0] result_high_byte_ff; // High byte of result pair
    logic [7:0] result_low_byte_ff; // Low byte of result pair
    logic [7:0] scan_res_ff [1:3]; // Scan results for inputs one to three
    logic [1:0] mode_ff; // Justification select
    logic [1:0] scan_cnt_ff; // Last scanned input
    logic scan_enable_ff; // Auto-scan enable
    logic continuous_convert_ff; // Continuous conversion bit
    logic conv_irq_enable_ff; // Interrupt enable bit
    logic conv_done_flag_ff; // Done flag (interrupts off)
    logic conv_irq_ff; // Conversion interrupt (interrupts on)
    logic lock_ff; // Pair frozen after high-byte read
    logic [1:0] scan_idx_ff; // Input being converted in scan
    arf_scan_state_t scan_state_ff; // Scan sequencer state
    logic [EV_NUM-1:0] ev_stat_ff; // Sticky event status
    logic [EV_NUM-1:0] ev_en_ff; // Event enables
    logic [7:0] rdata_ff; // Registered read data
    logic [7:0] nxt_high; // Formatted high byte
    logic [7:0] nxt_low; // Formatted low byte
    logic [EV_NUM-1:0] ev_pulse; // Events this cycle
    logic rd_high; // High-byte read
    logic rd_low; // Low-byte read
    logic sc_wr; // Status and control write
    logic scan_last; // Current scan input is the last one
    logic to_pair; // Conversion targets result pair

    assign rd_high = rd_in && (addr_in == ADDR_RESULT_HIGH);
    assign rd_low = rd_in && (addr_in == ADDR_RESULT_LOW);
    assign sc_wr = wr_in && (addr_in == ADDR_STATUS_CTRL);
    assign scan_last = (scan_idx_ff == scan_cnt_ff);
    // Scan inputs one to three go to their own registers
    assign to_pair = !(scan_state_ff == SCAN_RUN && scan_idx_ff != 2'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Justification formatting
    always_comb
    begin
        nxt_high = BYTE_RESET;
        nxt_low = BYTE_RESET;
        case (mode_ff)
            MODE_TRUNC:
            begin
                nxt_low = conv_data_in[9:2];
            end
            MODE_RIGHT:
            begin
                nxt_high = {6'h00, conv_data_in[9:8]};
                nxt_low = conv_data_in[7:0];
            end
            MODE_LEFT:
            begin
                nxt_high = conv_data_in[9:2];
                nxt_low = {conv_data_in[1:0], 6'h00};
            end
            MODE_LSIGN:
            begin
                nxt_high = {~conv_data_in[9], conv_data_in[8:2]};
                nxt_low = {conv_data_in[1:0], 6'h00};
            end
            default:
            begin
                nxt_high = BYTE_RESET;
                nxt_low = BYTE_RESET;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result pair with read-order interlock
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            result_high_byte_ff <= BYTE_RESET;
            result_low_byte_ff <= BYTE_RESET;
        end
        else if (conv_done_in && to_pair)
        begin
            if (mode_ff == MODE_TRUNC)
            begin
                // Truncated: low byte overwritten, high reads zero
                result_high_byte_ff <= BYTE_RESET;
                result_low_byte_ff <= nxt_low;
            end
            else if (!lock_ff && !rd_high)
            begin
                result_high_byte_ff <= nxt_high;
                result_low_byte_ff <= nxt_low;
            end
        end
    end

    // Lock set by high read, released by low read; truncated mode never locks
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            lock_ff <= 1'b0;
        end
        else if (mode_ff == MODE_TRUNC)
        begin
            lock_ff <= 1'b0;
        end
        else if (rd_high)
        begin
            lock_ff <= 1'b1;
        end
        else if (rd_low)
        begin
            lock_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Auto-scan result registers, one per extra input
    genvar gi;
    generate
        for (gi = 1; gi <= 3; gi++)
        begin : g_scan
            always_ff @(posedge clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                begin
                    scan_res_ff[gi] <= BYTE_RESET;
                end
                else if (conv_done_in && scan_state_ff == SCAN_RUN
                         && scan_idx_ff == 2'(gi))
                begin
                    scan_res_ff[gi] <= conv_data_in[9:2];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            mode_ff <= MODE_RESET;
            scan_cnt_ff <= SCAN_CNT_RESET;
            scan_enable_ff <= 1'b0;
            continuous_convert_ff <= 1'b0;
            conv_irq_enable_ff <= 1'b0;
            ev_en_ff <= '0;
        end
        else if (wr_in)
        begin
            case (addr_in)
                ADDR_SCAN_CONTROL:
                begin
                    scan_enable_ff <= wdata_in[SCAN_EN_BIT];
                    scan_cnt_ff <= wdata_in[SCAN_CNT_LO +: 2];
                end
                ADDR_MODE_CONTROL:
                begin
                    mode_ff <= wdata_in[MODE_LO +: 2];
                end
                ADDR_STATUS_CTRL:
                begin
                    conv_irq_enable_ff <= wdata_in[SC_IRQEN_BIT];
                    continuous_convert_ff <= wdata_in[SC_CONT_BIT];
                end
                ADDR_IRQ_ENABLE:
                begin
                    ev_en_ff <= wdata_in[EV_NUM-1:0];
                end
                default:
                begin
                    scan_enable_ff <= scan_enable_ff;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Auto-scan sequencer: input zero first, then ascending up to the count
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            scan_state_ff <= SCAN_IDLE;
            scan_idx_ff <= 2'h0;
        end
        else
        begin
            case (scan_state_ff)
                SCAN_IDLE:
                begin
                    scan_idx_ff <= 2'h0;
                    if (scan_enable_ff)
                    begin
                        scan_state_ff <= SCAN_RUN;
                    end
                end
                SCAN_RUN:
                begin
                    if (!scan_enable_ff)
                    begin
                        // Leave with input zero so the select never shows a stale input
                        scan_state_ff <= SCAN_IDLE;
                        scan_idx_ff <= 2'h0;
                    end
                    else if (conv_done_in)
                    begin
                        // Wrap to input zero after the last selected one
                        scan_idx_ff <= scan_last ? 2'h0 : scan_idx_ff + 2'h1;
                    end
                end
                default:
                begin
                    scan_state_ff <= SCAN_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Done flag and conversion interrupt; a new completion wins over a clear
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            conv_done_flag_ff <= 1'b0;
            conv_irq_ff <= 1'b0;
        end
        else
        begin
            if (conv_done_in && !conv_irq_enable_ff)
            begin
                conv_done_flag_ff <= 1'b1;
            end
            else if (rd_low || rd_high || conv_irq_enable_ff)
            begin
                conv_done_flag_ff <= 1'b0;
            end
            if (conv_done_in && conv_irq_enable_ff)
            begin
                conv_irq_ff <= 1'b1;
            end
            else if (rd_low || rd_high || sc_wr || !conv_irq_enable_ff)
            begin
                conv_irq_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky event status, write-one-to-clear, set wins
    assign ev_pulse[EV_CONV] = conv_done_in;
    assign ev_pulse[EV_LOST] = conv_done_in && to_pair && mode_ff != MODE_TRUNC
                               && (lock_ff || rd_high);
    assign ev_pulse[EV_CYCLE] = conv_done_in && scan_state_ff == SCAN_RUN && scan_last;

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ev_stat_ff <= '0;
        end
        else
        begin
            if (wr_in && addr_in == ADDR_IRQ_CLEAR)
            begin
                ev_stat_ff <= (ev_stat_ff & ~wdata_in[EV_NUM-1:0]) | ev_pulse;
            end
            else
            begin
                ev_stat_ff <= ev_stat_ff | ev_pulse;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rdata_ff <= BYTE_RESET;
        end
        else if (rd_in)
        begin
            case (addr_in)
                ADDR_STATUS_CTRL: rdata_ff <= {conv_done_flag_ff, conv_irq_enable_ff,
                                               continuous_convert_ff, 5'h00};
                ADDR_RESULT_HIGH: rdata_ff <= result_high_byte_ff;
                ADDR_RESULT_LOW: rdata_ff <= result_low_byte_ff;
                ADDR_SCAN_ONE: rdata_ff <= scan_res_ff[1];
                ADDR_SCAN_TWO: rdata_ff <= scan_res_ff[2];
                ADDR_SCAN_THREE: rdata_ff <= scan_res_ff[3];
                ADDR_SCAN_CONTROL: rdata_ff <= {5'h00, scan_enable_ff, scan_cnt_ff};
                ADDR_MODE_CONTROL: rdata_ff <= {6'h00, mode_ff};
                ADDR_IRQ_STATUS: rdata_ff <= {5'h00, ev_stat_ff};
                ADDR_IRQ_ENABLE: rdata_ff <= {5'h00, ev_en_ff};
                default: rdata_ff <= BYTE_RESET;
            endcase
        end
        else
        begin
            rdata_ff <= BYTE_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign rdata_out = rdata_ff;
    assign conv_input_out = scan_idx_ff;
    assign conv_start_out = (scan_state_ff == SCAN_RUN);
    assign continuous_convert_out = continuous_convert_ff;
    assign scan_active_out = (scan_state_ff == SCAN_RUN);
    assign conv_irq_out = conv_irq_ff;
    assign irq_out = |(ev_stat_ff & ev_en_ff);

endmodule // arf_core
`default_nettype wire

/* testbench/arf_core_props.sv */
// Checker: port-level properties of the result formatter
`timescale 1ns/1ps
`default_nettype none
module arf_core_props
    import arf_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    // Converter and status
    input wire logic conv_done_in,
    input wire logic [9:0] conv_data_in,
    input wire logic [1:0] conv_input_out,
    input wire logic scan_active_out,
    input wire logic conv_irq_out,
    input wire logic irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    ////////////////////////////////////////////////////////////
    logic [1:0] mode_ff; // Justification mode shadow
    logic [1:0] cnt_ff; // Scan count shadow
    logic irqen_ff; // Conversion interrupt enable shadow
    logic ien_ff; // Conversion event enable shadow
    logic lock_ff; // Pair frozen by a high-byte read
    logic [15:0] pair_ff; // Expected high and low bytes
    logic [9:0] cap_ff; // Last converter result
    logic [1:0] cap_in_ff; // Input of that result
    logic take; // Pair accepts this result
    logic [1:0] nxt_in; // Expected next scan input
    assign take = conv_done_in && !(scan_active_out && conv_input_out != 2'h0) &&
        (mode_ff == MODE_TRUNC || !(lock_ff || rd_in && addr_in == ADDR_RESULT_HIGH));
    assign nxt_in = (conv_input_out == cnt_ff) ? 2'h0 : conv_input_out + 2'h1;
    // Control shadows follow register writes
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            {mode_ff, cnt_ff, irqen_ff, ien_ff} <= {MODE_RESET, 4'h0};
        else if (wr_in)
        begin
            if (addr_in == ADDR_MODE_CONTROL) mode_ff <= wdata_in[1:0];
            if (addr_in == ADDR_SCAN_CONTROL) cnt_ff <= wdata_in[1:0];
            if (addr_in == ADDR_STATUS_CTRL) irqen_ff <= wdata_in[SC_IRQEN_BIT];
            if (addr_in == ADDR_IRQ_ENABLE) ien_ff <= wdata_in[EV_CONV];
        end
    end
    // Expected result pair with read-order lock
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            {lock_ff, pair_ff, cap_ff, cap_in_ff} <= '0;
        else
        begin
            if (rd_in && addr_in == ADDR_RESULT_HIGH) lock_ff <= 1'b1;
            if (rd_in && addr_in == ADDR_RESULT_LOW) lock_ff <= 1'b0;
            if (mode_ff == MODE_TRUNC) lock_ff <= 1'b0;
            if (conv_done_in) {cap_ff, cap_in_ff} <= {conv_data_in, conv_input_out};
            if (take)
            begin
                case (mode_ff)
                    MODE_TRUNC: pair_ff <= {8'h00, conv_data_in[9:2]};
                    MODE_RIGHT: pair_ff <= {6'h00, conv_data_in};
                    MODE_LEFT: pair_ff <= {conv_data_in, 6'h00};
                    default: pair_ff <= {~conv_data_in[9], conv_data_in[8:0], 6'h00};
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////
    AST_RD_IDLE: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data not zero outside answer");
    AST_HIGH_RD: assert property (rd_in && addr_in == ADDR_RESULT_HIGH &&
        !conv_done_in |=> rdata_out == $past(pair_ff[15:8])) else $error("high byte wrong");
    AST_LOW_RD: assert property (rd_in && addr_in == ADDR_RESULT_LOW &&
        !conv_done_in |=> rdata_out == $past(pair_ff[7:0])) else $error("low byte wrong");
    AST_SCAN_STEP: assert property (scan_active_out && conv_done_in && !wr_in
        |=> scan_active_out && conv_input_out == $past(nxt_in)) else $error("scan step wrong");
    AST_IDLE_INPUT: assert property (!scan_active_out |-> conv_input_out == 2'h0)
        else $error("input select not zero while idle");
    AST_SCAN_REG: assert property (scan_active_out && conv_done_in &&
        conv_input_out != 2'h0 ##1 !conv_done_in ##1 (rd_in && !conv_done_in &&
        addr_in == ADDR_RESULT_LOW + {6'h00, cap_in_ff}) |=> rdata_out == cap_ff[9:2])
        else $error("scan register wrong");
    AST_IRQ_SET: assert property (conv_done_in && irqen_ff && !wr_in |=> conv_irq_out)
        else $error("conversion interrupt not raised");
    AST_IRQ_CLR: assert property (rd_in && addr_in == ADDR_RESULT_HIGH &&
        !conv_done_in |=> !conv_irq_out) else $error("conversion interrupt not cleared");
    AST_DONE_FLAG: assert property (conv_done_in && !irqen_ff && !wr_in ##1
        !rd_in && !wr_in ##1 (rd_in && addr_in == ADDR_STATUS_CTRL)
        |=> rdata_out[SC_DONE_BIT]) else $error("done flag not set");
    AST_IRQ_OUT: assert property (conv_done_in && ien_ff && !wr_in |=> irq_out)
        else $error("interrupt line not raised");
endmodule // arf_core_props
bind arf_core arf_core_props u_props (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .conv_done_in(conv_done_in), .conv_data_in(conv_data_in),
    .conv_input_out(conv_input_out), .scan_active_out(scan_active_out),
    .conv_irq_out(conv_irq_out), .irq_out(irq_out));
`default_nettype wire

/* testbench/arf_conv_model.sv */
// Converter stand-in: returns one result after a chosen wait
`timescale 1ns/1ps
`default_nettype none
module arf_conv_model
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Requests from the bench
    input wire logic go_in,
    input wire logic [3:0] wait_in,
    input wire logic [9:0] val_in,
    // Toward the formatter
    output logic done_out,
    output logic [9:0] data_out
);
    logic busy_ff; // Conversion running
    logic [3:0] cnt_ff; // Cycles still to wait
    logic [9:0] val_ff; // Result to deliver
    // One-cycle done pulse; data lines churn outside it
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            {busy_ff, cnt_ff, val_ff, done_out, data_out} <= '0;
        else
        begin
            done_out <= busy_ff && cnt_ff == 4'h0;
            data_out <= (busy_ff && cnt_ff == 4'h0) ? val_ff : ~data_out;
            if (go_in)
                {busy_ff, cnt_ff, val_ff} <= {1'b1, wait_in, val_in};
            else if (busy_ff)
            begin
                busy_ff <= cnt_ff != 4'h0;
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end
endmodule // arf_conv_model
`default_nettype wire

/* testbench/arf_core_tb_top.sv */
// Testbench: result formatter against a bench model
`timescale 1ns/1ps
`default_nettype none
module arf_core_tb_top;
    import arf_pkg::*;
    logic clk = 1'b0; // Bus clock, 20 MHz
    logic rstn; // Reset, active low
    logic [7:0] addr, wdata, rdata; // Register port
    logic wr, rd, go, done, scan, start, cirq, irq, cont; // Strobes and levels
    logic [3:0] wt; // Converter wait
    logic [9:0] val, data; // Converter values
    logic [1:0] cin; // Scan input select
    logic [15:0] rnd; // Random state
    logic [9:0] sq[$]; // Results of one scan cycle
    int errors = 0; // Mismatches
    int samples_checked = 0; // Comparisons
    always #25 clk = ~clk;
    arf_core uut (.clk_in(clk), .rstn_in(rstn), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .conv_done_in(done),
        .conv_data_in(data), .conv_input_out(cin), .conv_start_out(start),
        .continuous_convert_out(cont), .scan_active_out(scan), .conv_irq_out(cirq),
        .irq_out(irq));
    arf_conv_model conv_side (.clk_in(clk), .rstn_in(rstn), .go_in(go), .wait_in(wt),
        .val_in(val), .done_out(done), .data_out(data));
    ////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Expected high and low bytes for one result
    function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] v);
        case (m)
            MODE_TRUNC: return {8'h00, v[9:2]};
            MODE_RIGHT: return {6'h00, v};
            MODE_LEFT: return {v, 6'h00};
            default: return {~v[9], v[8:0], 6'h00};
        endcase
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk({8'h00, rdata & m}, {8'h00, e});
    endtask
    // One conversion; returns at the edge that takes it
    task automatic conv(input logic [9:0] v, input logic [3:0] w);
        int n;
        n = 0;
        @(posedge clk);
        {go, val, wt} <= {1'b1, v, w};
        @(posedge clk);
        go <= 1'b0;
        while (done !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({15'h0, done}, 16'h1);
        @(posedge clk);
    endtask
    task automatic pair(input logic [1:0] m);
        logic [15:0] e;
        rnd = lfsr(rnd);
        e = fmt(m, rnd[9:0]);
        conv(rnd[9:0], rnd[13:10]);
        rd_chk(ADDR_RESULT_HIGH, e[15:8], 8'hFF);
        rd_chk(ADDR_RESULT_LOW, e[7:0], 8'hFF);
    endtask
    task complete_run;
        $display("Checks %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        logic [15:0] e;
        rnd = 16'hAB2E;
        {addr, wdata, wr, rd, go, wt, val} <= '0;
        rstn <= 1'b0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(ADDR_RESULT_HIGH, 8'h00, 8'hFF);
        rd_chk(ADDR_RESULT_LOW, 8'h00, 8'hFF);
        rd_chk(ADDR_SCAN_CONTROL, 8'h00, 8'h07);
        rd_chk(ADDR_MODE_CONTROL, {6'h00, MODE_RESET}, 8'h03);
        wr_reg(ADDR_RESULT_LOW, rnd[7:0]);
        rd_chk(ADDR_RESULT_LOW, 8'h00, 8'hFF);
        rd_chk(8'h70, 8'h00, 8'hFF);
        // Every justification mode
        for (int m = 0; m < 4; m++)
        begin
            wr_reg(ADDR_MODE_CONTROL, m[7:0]);
            pair(m[1:0]);
        end
        // High read freezes the pair until the low read
        wr_reg(ADDR_MODE_CONTROL, 8'h01);
        rnd = lfsr(rnd);
        e = fmt(MODE_RIGHT, rnd[9:0]);
        conv(rnd[9:0], 4'h0);
        rd_chk(ADDR_RESULT_HIGH, e[15:8], 8'hFF);
        conv(~rnd[9:0], 4'h3);
        rd_chk(ADDR_RESULT_LOW, e[7:0], 8'hFF);
        pair(MODE_RIGHT);
        // Truncated mode has no lock
        wr_reg(ADDR_MODE_CONTROL, 8'h00);
        pair(MODE_TRUNC);
        rd_chk(ADDR_RESULT_HIGH, 8'h00, 8'hFF);
        conv(rnd[15:6], 4'h2);
        rd_chk(ADDR_RESULT_LOW, rnd[15:8], 8'hFF);
        // Auto-scan over every count
        for (int c = 0; c < 4; c++)
        begin
            wr_reg(ADDR_SCAN_CONTROL, 8'h04 | c[7:0]);
            // Sequencer leaves idle one edge after the enable lands
            @(posedge clk);
            sq.delete();
            for (int i = 0; i <= c; i++)
            begin
                @(negedge clk);
                chk({12'h000, scan, start, cin}, {12'h000, 2'b11, i[1:0]});
                rnd = lfsr(rnd);
                sq.push_back(rnd[9:0]);
                conv(rnd[9:0], rnd[13:10]);
                if (i > 0) rd_chk(ADDR_RESULT_LOW + i[7:0], rnd[9:2], 8'hFF);
            end
            @(negedge clk);
            chk({14'h0, cin}, 16'h0);
            wr_reg(ADDR_SCAN_CONTROL, 8'h00);
            rd_chk(ADDR_RESULT_LOW, sq[0][9:2], 8'hFF);
            chk({15'h0, scan}, 16'h0);
        end
        // Sticky events: conversion, dropped result, finished scan cycle
        rd_chk(ADDR_IRQ_STATUS, 8'h07, 8'h07);
        // Interrupts: raise, clear, mask, done flag
        wr_reg(ADDR_IRQ_CLEAR, 8'h07);
        wr_reg(ADDR_IRQ_ENABLE, 8'h01);
        wr_reg(ADDR_STATUS_CTRL, 8'h40);
        #1;
        chk({14'h0, cirq, irq}, 16'h0);
        conv(rnd[15:6], 4'h1);
        #1;
        chk({14'h0, cirq, irq}, 16'h3);
        rd_chk(ADDR_STATUS_CTRL, 8'h00, 8'h80);
        rd_chk(ADDR_RESULT_HIGH, 8'h00, 8'hFF);
        chk({14'h0, cirq, irq}, 16'h1);
        rd_chk(ADDR_RESULT_LOW, rnd[15:8], 8'hFF);
        wr_reg(ADDR_IRQ_CLEAR, 8'h01);
        wr_reg(ADDR_IRQ_ENABLE, 8'h00);
        conv(rnd[9:0], 4'h0);
        #1;
        chk({15'h0, irq}, 16'h0);
        rd_chk(ADDR_IRQ_STATUS, 8'h01, 8'h01);
        // Interrupts off, continuous on while scan is off
        wr_reg(ADDR_STATUS_CTRL, 8'h20);
        #1;
        chk({15'h0, cont}, 16'h1);
        conv(rnd[9:0], 4'h5);
        rd_chk(ADDR_STATUS_CTRL, 8'h80, 8'h80);
        rd_chk(ADDR_RESULT_LOW, rnd[9:2], 8'hFF);
        rd_chk(ADDR_STATUS_CTRL, 8'h00, 8'h80);
        complete_run();
    end
    // Watchdog against a hang
    initial
    begin
        #1000000;
        errors++;
        complete_run();
    end
endmodule // arf_core_tb_top
`default_nettype wire
